// ===== verilog/command_redriver_parity_rank.sv
// command redriver with parity gate, control words, I2C slave and rank decode
`timescale 1ns/1ps
`default_nettype none
module command_redriver_parity_rank
#(
  parameter int NUM_CK_OUT = 4
)
(
  input  wire logic                    clk_sys,
  input  wire logic                    reset,
  input  wire logic                    cmd_clk_t,
  input  wire logic                    cmd_clk_c,
  input  wire redriver_pkg::cmd_s      cmd_in,
  input  wire logic                    cmd_parity_in,
  input  wire logic [2:0]              slot_addr,
  input  wire logic                    scl_in,
  input  wire logic                    sda_in,
  output logic                         sda_out,
  output logic                         sda_oe_n,
  output logic                         alert_out,
  output logic                         alert_oe_n,
  output redriver_pkg::drv_s           dram_cmd,
  output logic [NUM_CK_OUT-1:0]        ck_out_t,
  output logic [NUM_CK_OUT-1:0]        ck_out_c
);
  import redriver_pkg::*;

  initial
  begin
    if (NUM_CK_OUT < 1 || NUM_CK_OUT > 16)
      $error("NUM_CK_OUT out of range");
  end

  // ----------------------------------------
  // rank decode
  // ----------------------------------------
  // reserved mode code falls back to two-select so a bad config never floods all ranks
  function automatic logic [3:0] map_cs(input logic [1:0] mode, input logic [3:0] cs);
    logic [3:0] r;
    r = CS_IDLE;
    case (mode)
      four_select_mode: r = cs;
      four_encoded:     r = cs[0] ? CS_IDLE : ~(4'h1 << cs[2:1]);
      default:          r = {2'b11, cs[1:0]};
    endcase
    return r;
  endfunction

  st_s        st_ff;
  st_s        nxt_st;
  logic [1:0] rank_mode_field;
  logic       par_en;
  logic       ck_rise;
  logic       ev_cmd;
  logic       par_bad;
  logic [3:0] mapped_cs;
  logic [3:0] cw_idx;
  logic [3:0] cw_data;

  assign rank_mode_field = st_ff.cw[CW_CONFIG_IDX][1:0];
  assign par_en    = st_ff.cw[CW_PARITY_IDX][PAR_EN_BIT];
  assign ck_rise   = st_ff.ck_sync[1] & st_ff.ck_sync[2] & ~st_ff.ck_q;
  assign mapped_cs = map_cs(rank_mode_field, st_ff.cmd3.cs_n);
  assign ev_cmd    = ck_rise & (mapped_cs != CS_IDLE);
  // even parity: ones across qualified bits and parity bit must be even
  assign par_bad   = ^{st_ff.cmd3.cw_sel, st_ff.cmd3.addr, st_ff.par_sync[2]};
  assign cw_idx    = st_ff.cmd3.addr[CW_IDX_LSB +: 4];
  assign cw_data   = st_ff.cmd3.addr[CW_DATA_LSB +: 4];

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    logic scl_new;
    logic sda_new;
    logic scl_rise;
    logic scl_fall;
    logic i2c_start;
    logic i2c_stop;
    scl_new   = 1'b0;
    sda_new   = 1'b0;
    scl_rise  = 1'b0;
    scl_fall  = 1'b0;
    i2c_start = 1'b0;
    i2c_stop  = 1'b0;
    nxt_st = st_ff;
    // three-stage sampling, a change counts once stages two and three agree
    nxt_st.ck_sync  = {st_ff.ck_sync[1:0], cmd_clk_t & ~cmd_clk_c};
    nxt_st.par_sync = {st_ff.par_sync[1:0], cmd_parity_in};
    nxt_st.scl_sync = {st_ff.scl_sync[1:0], scl_in};
    nxt_st.sda_sync = {st_ff.sda_sync[1:0], sda_in};
    nxt_st.cmd1     = cmd_in;
    nxt_st.cmd2     = st_ff.cmd1;
    nxt_st.cmd3     = st_ff.cmd2;
    nxt_st.sa1      = slot_addr;
    nxt_st.sa2      = st_ff.sa1;
    nxt_st.sa3      = st_ff.sa2;
    if (st_ff.ck_sync[1] == st_ff.ck_sync[2])
      nxt_st.ck_q = st_ff.ck_sync[2];
    scl_new = (st_ff.scl_sync[1] == st_ff.scl_sync[2]) ? st_ff.scl_sync[2] : st_ff.scl_q;
    sda_new = (st_ff.sda_sync[1] == st_ff.sda_sync[2]) ? st_ff.sda_sync[2] : st_ff.sda_q;
    nxt_st.scl_q = scl_new;
    nxt_st.sda_q = sda_new;
    scl_rise  = ~st_ff.scl_q & scl_new;
    scl_fall  = st_ff.scl_q & ~scl_new;
    i2c_start = st_ff.scl_q & scl_new & st_ff.sda_q & ~sda_new;
    i2c_stop  = st_ff.scl_q & scl_new & ~st_ff.sda_q & sda_new;

    // clock fan-out follows the accepted command clock level
    nxt_st.ck_out = nxt_st.ck_q;

    // ----------------------------------------
    // I2C write-only slave
    // ----------------------------------------
    // reads are not served; a read address is left unacknowledged
    case (st_ff.i2c)
      I_IDLE: ;
      I_RX:
      begin
        if (scl_rise)
        begin
          nxt_st.shreg  = {st_ff.shreg[6:0], sda_new};
          nxt_st.bitcnt = st_ff.bitcnt + 4'h1;
        end
        if (scl_fall && st_ff.bitcnt == I2C_BYTE_BITS)
        begin
          nxt_st.bitcnt   = 4'h0;
          nxt_st.sda_oe_n = 1'b0;
          nxt_st.i2c      = I_ACK;
          if (st_ff.byte_no != 2'h3)
            nxt_st.byte_no = st_ff.byte_no + 2'h1;
          if (st_ff.byte_no == 2'h0)
          begin
            if (st_ff.shreg[7:1] != {I2C_BASE[3:0], st_ff.sa3} || st_ff.shreg[0])
            begin
              nxt_st.sda_oe_n = 1'b1;
              nxt_st.i2c      = I_SKIP;
            end
          end
          else if (st_ff.byte_no == 2'h1)
            nxt_st.idx = st_ff.shreg[3:0];
          else
          begin
            nxt_st.cw[st_ff.idx] = st_ff.shreg[3:0];
            nxt_st.idx           = st_ff.idx + 4'h1;
          end
        end
      end
      I_ACK:
      begin
        if (scl_fall)
        begin
          nxt_st.sda_oe_n = 1'b1;
          nxt_st.i2c      = I_RX;
        end
      end
      I_SKIP: ;
      default: nxt_st.i2c = I_IDLE;
    endcase
    if (i2c_start)
    begin
      nxt_st.i2c      = I_RX;
      nxt_st.bitcnt   = 4'h0;
      nxt_st.byte_no  = 2'h0;
      nxt_st.sda_oe_n = 1'b1;
    end
    else if (i2c_stop)
    begin
      nxt_st.i2c      = I_IDLE;
      nxt_st.sda_oe_n = 1'b1;
    end

    // ----------------------------------------
    // command path and parity gate
    // ----------------------------------------
    nxt_st.q.valid = 1'b0;
    if (st_ff.alert_cnt != 5'h0)
      nxt_st.alert_cnt = st_ff.alert_cnt - 5'h1;
    if (ev_cmd)
    begin
      if (par_en && par_bad)
        nxt_st.alert_cnt = ALERT_LOAD;
      else if (st_ff.cmd3.cw_sel)
        nxt_st.cw[cw_idx] = cw_data;
      else
      begin
        nxt_st.q.valid = 1'b1;
        nxt_st.q.cs_n  = mapped_cs;
        nxt_st.q.addr  = st_ff.cmd3.addr;
      end
    end
    nxt_st.alert_oe_n = (nxt_st.alert_cnt == 5'h0);

    if (reset)
    begin
      nxt_st            = '0;
      nxt_st.cmd1.cs_n  = CS_IDLE;
      nxt_st.cmd2.cs_n  = CS_IDLE;
      nxt_st.cmd3.cs_n  = CS_IDLE;
      nxt_st.scl_sync   = 3'h7;
      nxt_st.sda_sync   = 3'h7;
      nxt_st.scl_q      = 1'b1;
      nxt_st.sda_q      = 1'b1;
      nxt_st.i2c        = I_IDLE;
      nxt_st.sda_oe_n   = 1'b1;
      nxt_st.cw         = {16{CW_RESET}};
      nxt_st.alert_oe_n = 1'b1;
      nxt_st.q.cs_n     = CS_IDLE;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    st_ff <= nxt_st;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign sda_out    = 1'b0;
  assign alert_out  = 1'b0;
  assign sda_oe_n   = st_ff.sda_oe_n;
  assign alert_oe_n = st_ff.alert_oe_n;
  assign dram_cmd   = st_ff.q;
  assign ck_out_t   = {NUM_CK_OUT{st_ff.ck_out}};
  assign ck_out_c   = {NUM_CK_OUT{~st_ff.ck_out}};

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_cmd_good;
    ev_cmd && !st_ff.cmd3.cw_sel && (!par_en || !par_bad);
  endsequence

  sequence s_cmd_bad;
    ev_cmd && par_en && par_bad;
  endsequence

  a_fwd_good_cmd: assert property (s_cmd_good |=> dram_cmd.valid
    && dram_cmd.addr == $past(st_ff.cmd3.addr))
    else $error("clean command not forwarded");
  a_drop_bad_cmd: assert property (s_cmd_bad |=> !dram_cmd.valid && !alert_oe_n)
    else $error("bad-parity command forwarded");
  a_fwd_unchecked: assert property (ev_cmd && !par_en && !st_ff.cmd3.cw_sel
    |=> dram_cmd.valid)
    else $error("command dropped with parity off");
  a_alert_hold: assert property (s_cmd_bad |=> !alert_oe_n [*8])
    else $error("alert too short");
  a_cw_discard: assert property (s_cmd_bad ##0 st_ff.cmd3.cw_sel
    ##1 st_ff.i2c != I_RX |-> $stable(st_ff.cw))
    else $error("failed control word write stored");
  a_cw_update: assert property (ev_cmd && st_ff.cmd3.cw_sel && (!par_en || !par_bad)
    |=> st_ff.cw[$past(cw_idx)] == $past(cw_data))
    else $error("control word not written");
  a_rank_two: assert property (dram_cmd.valid && rank_mode_field == two_select_mode
    |-> dram_cmd.cs_n[3:2] == 2'b11)
    else $error("upper ranks selected in two-select mode");
  a_valid_on_edge: assert property ($rose(dram_cmd.valid) |-> $past(ck_rise))
    else $error("command issued without clock edge");
  // fan-out must follow the settled sampler level, not the raw pin
  a_ck_fanout: assert property (st_ff.ck_sync[1] == st_ff.ck_sync[2]
    |=> ck_out_t == {NUM_CK_OUT{$past(st_ff.ck_sync[2])}} && ck_out_c == ~ck_out_t)
    else $error("clock fan-out mismatch");

endmodule
`default_nettype wire

// ===== verilog/redriver_pkg.sv
// constants, types and state layout of the command redriver
// Behaviour
// - parity checking is switched on or off by a bit in a control word
// - host drives a parity bit per command; device compares it with sampled inputs
// - a parity mismatch is reported on the open-drain active-low alert output
// - with checking on, only commands without mismatch reach the DRAM devices
// - with checking off, every sampled command other than a control word write is forwarded regardless of parity
// - control word writes are parity checked too, unless checking is off
// - control words are written over the command bus or over the I2C slave
// - one load per input; signals are redriven to all DRAM devices
// - one incoming clock pair is redistributed to several output clock pairs
// - command, address and control are captured on the command clock pair
// - active-low chip-selects choose the DRAM rank for a command
// - three rank modes, chosen by a two-bit field of the configuration word
// - direct two-select mode maps each select straight onto one rank
// - four-rank modules use direct or encoded four-select mode
// - I2C slave answers at 0x58-0x5F, low three bits from slot address pins
package redriver_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_NS    = 25;
  localparam int ALERT_NS  = 600;
  localparam int ALERT_CYC = (ALERT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [4:0] ALERT_LOAD = 5'(ALERT_CYC);

  // ----------------------------------------
  // command word layout
  // ----------------------------------------
  localparam int CMD_ADDR_W  = 18;
  localparam int CW_IDX_LSB  = 0;
  localparam int CW_DATA_LSB = 4;
  localparam int PAR_EN_BIT  = 0;

  localparam logic [3:0] CW_CONFIG_IDX = 4'h0;
  localparam logic [3:0] CW_PARITY_IDX = 4'hE;
  localparam logic [3:0] CW_RESET      = 4'h0;
  localparam logic [3:0] CS_IDLE       = 4'hF;
  localparam logic [3:0] I2C_BASE      = 4'hB;
  localparam logic [3:0] I2C_BYTE_BITS = 4'h8;

  typedef enum logic [1:0]
  {
    two_select_mode  = 2'b00,
    four_select_mode = 2'b01,
    four_encoded     = 2'b10
  } rank_mode_e;

  typedef enum logic [1:0]
  {
    I_IDLE = 2'b00,
    I_RX   = 2'b01,
    I_ACK  = 2'b10,
    I_SKIP = 2'b11
  } i2c_state_e;

  typedef struct packed
  {
    logic [3:0]            cs_n;
    logic                  cw_sel;
    logic [CMD_ADDR_W-1:0] addr;
  } cmd_s;

  typedef struct packed
  {
    logic [3:0]            cs_n;
    logic [CMD_ADDR_W-1:0] addr;
    logic                  valid;
  } drv_s;

  typedef struct packed
  {
    logic [2:0]      ck_sync;
    logic            ck_q;
    cmd_s            cmd1;
    cmd_s            cmd2;
    cmd_s            cmd3;
    logic [2:0]      par_sync;
    logic [2:0]      scl_sync;
    logic [2:0]      sda_sync;
    logic [2:0]      sa1;
    logic [2:0]      sa2;
    logic [2:0]      sa3;
    logic            scl_q;
    logic            sda_q;
    i2c_state_e      i2c;
    logic [3:0]      bitcnt;
    logic [7:0]      shreg;
    logic [1:0]      byte_no;
    logic [3:0]      idx;
    logic            sda_oe_n;
    logic [15:0][3:0] cw;
    logic [4:0]      alert_cnt;
    logic            alert_oe_n;
    drv_s            q;
    logic            ck_out;
  } st_s;

endpackage

// ===== tb/host_cmd_model.sv
// host controller model that drives the command bus of the redriver
`timescale 1ns/1ps
`default_nettype none
module host_cmd_model
(
  input  wire logic          clk_sys,
  output logic               cmd_clk_t,
  output logic               cmd_clk_c,
  output redriver_pkg::cmd_s cmd_in,
  output logic               cmd_parity_in
);
  import redriver_pkg::*;

  // clock pulses only inside a transfer and stands still between them
  initial
  begin
    cmd_clk_t     = 1'b0;
    cmd_in        = '{cs_n: CS_IDLE, cw_sel: 1'b0, addr: '0};
    cmd_parity_in = 1'b0;
  end
  assign cmd_clk_c = ~cmd_clk_t;

  task automatic send(input logic [3:0] cs, input logic cw, input logic [17:0] a,
                      input logic bad);
    @(negedge clk_sys);
    cmd_in        = '{cs_n: cs, cw_sel: cw, addr: a};
    cmd_parity_in = ^{cw, a} ^ bad;
    repeat (4) @(negedge clk_sys);
    cmd_clk_t = 1'b1;
    repeat (4) @(negedge clk_sys);
    cmd_clk_t = 1'b0;
    // hold over: show the inverse so a stale value cannot pass for a sample
    cmd_in        = '{cs_n: CS_IDLE, cw_sel: ~cw, addr: ~a};
    cmd_parity_in = ~cmd_parity_in;
  endtask
endmodule
`default_nettype wire

// ===== tb/command_redriver_parity_rank_tb_top.sv
// self-checking bench for the command redriver
`timescale 1ns/1ps
`default_nettype none
module command_redriver_parity_rank_tb_top;
  import redriver_pkg::*;
  localparam int H = 8;
  logic       clk_sys    = 1'b0;
  logic       reset      = 1'b1;
  logic       scl_h      = 1'b1;
  logic       sda_h      = 1'b1;
  logic [2:0] slot_addr  = 3'h5;
  logic       alert_seen = 1'b0;
  logic       cmd_clk_t, cmd_clk_c, cmd_parity_in, sda_in;
  logic       sda_out, sda_oe_n, alert_out, alert_oe_n;
  logic [3:0] ck_out_t, ck_out_c;
  cmd_s       cmd_in;
  drv_s       dram_cmd, got;
  int         mismatches = 0, samples_checked = 0, nvalid = 0, n0;

  always #12.5 clk_sys = ~clk_sys;
  // open-drain sda: wired-and of host and device
  assign sda_in = sda_h & (sda_oe_n | sda_out);

  host_cmd_model host (.clk_sys(clk_sys), .cmd_clk_t(cmd_clk_t), .cmd_clk_c(cmd_clk_c),
    .cmd_in(cmd_in), .cmd_parity_in(cmd_parity_in));

  command_redriver_parity_rank #(.NUM_CK_OUT(4)) DUT (.clk_sys(clk_sys), .reset(reset),
    .cmd_clk_t(cmd_clk_t), .cmd_clk_c(cmd_clk_c), .cmd_in(cmd_in),
    .cmd_parity_in(cmd_parity_in), .slot_addr(slot_addr), .scl_in(scl_h),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .alert_out(alert_out),
    .alert_oe_n(alert_oe_n), .dram_cmd(dram_cmd), .ck_out_t(ck_out_t),
    .ck_out_c(ck_out_c));

  // valid is a one-cycle pulse, so capture it at the edge
  always @(posedge clk_sys)
  begin
    if (dram_cmd.valid === 1'b1)
    begin
      got = dram_cmd;
      nvalid++;
    end
    if (alert_oe_n === 1'b0)
      alert_seen = 1'b1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic issue(input logic [3:0] cs, input logic cw, input logic [17:0] a,
                       input logic bad);
    n0         = nvalid;
    alert_seen = 1'b0;
    host.send(cs, cw, a, bad);
    repeat (4) @(negedge clk_sys);
  endtask

  // sda moves a few cycles after scl falls, never beside the fall
  task automatic i2c_bit(input logic v);
    repeat (3) @(negedge clk_sys);
    sda_h = v;
    repeat (H) @(negedge clk_sys);
    scl_h = 1'b1;
    repeat (H) @(negedge clk_sys);
    scl_h = 1'b0;
  endtask

  task automatic i2c_start();
    sda_h = 1'b0;
    repeat (H) @(negedge clk_sys);
    scl_h = 1'b0;
  endtask

  task automatic i2c_stop();
    repeat (3) @(negedge clk_sys);
    sda_h = 1'b0;
    repeat (H) @(negedge clk_sys);
    scl_h = 1'b1;
    repeat (H) @(negedge clk_sys);
    sda_h = 1'b1;
    repeat (H) @(negedge clk_sys);
  endtask

  task automatic i2c_byte(input logic [7:0] b, input logic ack_n);
    for (int i = 7; i >= 0; i--)
      i2c_bit(b[i]);
    repeat (3) @(negedge clk_sys);
    sda_h = 1'b1;
    repeat (H) @(negedge clk_sys);
    scl_h = 1'b1;
    repeat (4) @(negedge clk_sys);
    check(sda_oe_n, ack_n);
    repeat (4) @(negedge clk_sys);
    scl_h = 1'b0;
  endtask

  task automatic t_parity_off();
    check({dram_cmd.valid, alert_oe_n, sda_oe_n}, 3'b011);
    check({alert_out, sda_out}, 2'b00);
    issue(4'hD, 1'b0, 18'h2A5C3, 1'b1);
    check(nvalid - n0, 1);
    check(alert_seen, 1'b0);
    check(got.addr, 18'h2A5C3);
    check(got.cs_n, 4'hD);
    check({ck_out_t, ck_out_c}, 8'h0F);
  endtask

  task automatic t_rank_modes();
    logic [3:0] exp_cs [4];
    exp_cs = '{4'hE, 4'hA, 4'hD, 4'hE};
    for (int m = 0; m < 4; m++)
    begin
      issue(4'hE, 1'b1, {12'h000, 2'(m), CW_CONFIG_IDX}, 1'b0);
      check(nvalid - n0, 0);
      issue(4'hA, 1'b0, 18'h0F0F0, 1'b0);
      check(got.cs_n, exp_cs[m]);
    end
  endtask

  task automatic t_i2c_parity_on();
    i2c_start();
    i2c_byte({I2C_BASE, slot_addr, 1'b0}, 1'b0);
    i2c_byte({4'h0, CW_PARITY_IDX}, 1'b0);
    i2c_byte(8'h01, 1'b0);
    i2c_stop();
    issue(4'hE, 1'b0, 18'h12345, 1'b1);
    check(nvalid - n0, 0);
    check(alert_seen, 1'b1);
    repeat (30) @(negedge clk_sys);
    issue(4'hE, 1'b0, 18'h12345, 1'b0);
    check(nvalid - n0, 1);
    check(alert_seen, 1'b0);
  endtask

  // another slot's address: no acknowledge, and mode 3 must survive
  task automatic t_i2c_wrong_slot();
    i2c_start();
    i2c_byte({I2C_BASE, slot_addr ^ 3'h1, 1'b0}, 1'b1);
    i2c_byte({4'h0, CW_CONFIG_IDX}, 1'b1);
    i2c_byte(8'h01, 1'b1);
    i2c_stop();
    issue(4'h6, 1'b0, 18'h0A5A5, 1'b0);
    check(nvalid - n0, 1);
    check(got.cs_n, 4'hE);
  endtask

  // mode is 3 here, read as two-select; a dropped write must keep it
  task automatic t_bad_cw();
    issue(4'hE, 1'b1, {10'h000, 4'h1, CW_CONFIG_IDX}, 1'b1);
    check(alert_seen, 1'b1);
    repeat (30) @(negedge clk_sys);
    issue(4'h6, 1'b0, 18'h3C3C3, 1'b0);
    check(got.cs_n, 4'hE);
  endtask

  initial
  begin
    #2000000;
    mismatches++;
    close_out();
  end

  initial
  begin
    repeat (16) @(negedge clk_sys);
    reset = 1'b0;
    repeat (4) @(negedge clk_sys);
    t_parity_off();
    t_rank_modes();
    t_i2c_parity_on();
    t_i2c_wrong_slot();
    t_bad_cw();
    close_out();
  end
endmodule
`default_nettype wire
